// *** rtl/eec_cfg.svh ***
`ifndef EEC_CFG_SVH
`define EEC_CFG_SVH

`define EEC_OFS_DIVH     12'h0EE
`define EEC_OFS_DIVL     12'h0EF
`define EEC_OFS_MCR      12'h0F0
`define EEC_OFS_PROT     12'h0F1
`define EEC_OFS_CTRL     12'h0F3
`define EEC_ARR_SEL      2'h3
`define EEC_SHADOW_HI    10'h3C0

`define EEC_MCR_DBG      7
`define EEC_MCR_SHADOW_DISABLE    6
`define EEC_MCR_FPO      4
`define EEC_MCR_ONE      3
`define EEC_MCR_SWAI     2
`define EEC_MCR_LCK      1
`define EEC_MCR_DMY      0
`define EEC_PROT_SH      7
`define EEC_CTRL_BULKP   7
`define EEC_CTRL_AUTO    5
`define EEC_CTRL_BYTE    4
`define EEC_CTRL_ROW     3
`define EEC_CTRL_ERASE   2
`define EEC_CTRL_LAT     1
`define EEC_CTRL_PGM     0

`define EEC_MCR_RST      8'h0C
`define EEC_PROT_RST     8'h9F
`define EEC_CTRL_RST     8'h80
`define EEC_SHADOW_INIT  16'hFFFF

`define EEC_PROG_TIME_US 10000
`define EEC_TICK_US      35
`define EEC_PROG_TICKS   ((`EEC_PROG_TIME_US + `EEC_TICK_US - 1) / `EEC_TICK_US)

`endif

// *** rtl/eec_ctrl.sv ***
`timescale 1ns/1ns
`include "eec_cfg.svh"

module eec_ctrl #(
  parameter int TICKS = `EEC_PROG_TICKS
) (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        special_mode_n_i,
  input  wire logic [11:0] bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  output logic      [7:0]  bus_rdata_o,
  input  wire logic [7:0]  arr_rdata_i,
  output logic      [9:0]  arr_addr_o,
  output logic      [7:0]  arr_wdata_o,
  output logic             arr_erase_o,
  output logic      [1:0]  arr_erase_mode_o,
  output logic             arr_hv_o,
  output logic             arr_latch_o,
  output logic             debug_lockout_disable_o,
  output logic             flash_program_open_o
);

  eec_pkg::eec_state_e state_reg;
  eec_pkg::eec_state_e state_next;
  eec_pkg::eec_op_s    op_reg;

  logic [7:0]  module_config_register_reg;
  logic [7:0]  block_protect_register_reg;
  logic [7:0]  ctrl_reg;
  logic [1:0]  clock_divider_high_reg;
  logic [7:0]  clock_divider_low_reg;
  logic        div_lock_hi_reg;
  logic        div_lock_lo_reg;
  logic        lck_once_reg;
  logic        hv_reg;
  logic [7:0]  rdata_reg;
  // nonvolatile word: no reset, starts erased
  logic [15:0] shadow_reg = `EEC_SHADOW_INIT;

  logic [9:0]  clock_divider_value;
  logic        load;
  logic        idle;
  logic        pgm;
  logic        lat;
  logic        div_zero;
  logic        special;
  logic        arr_hit;
  logic [9:0]  arr_ofs;
  logic        shadow_hit;
  logic        wr_mcr;
  logic        wr_prot;
  logic        wr_ctrl;
  logic        wr_divh;
  logic        wr_divl;
  logic        latch_wr;
  logic        pgm_set_ok;
  logic        erase;
  logic        multi_erase;
  logic        shadow_all;
  logic        shadow_touch;
  logic        blocked;
  logic        start;
  logic        done;
  logic        abort;
  logic [7:0]  ctrl_next;
  logic [7:0]  mcr_next;
  logic [7:0]  rd_mux;

  // block protect ranges by array offset
  function automatic logic blk_prot(input logic [9:0] a, input logic [4:0] bp);
    logic r;
    r = 1'b0;
    if (a[9] == 1'b0)
      r = bp[4];
    else if (a[8] == 1'b0)
      r = bp[3];
    else if (a[7] == 1'b0)
      r = bp[2];
    else if (a[6] == 1'b0)
      r = bp[1];
    else
      r = bp[0];
    return r;
  endfunction : blk_prot

  // address decode and status terms
  assign load       = (state_reg == eec_pkg::EEC_ST_LOAD);
  assign idle       = (state_reg == eec_pkg::EEC_ST_IDLE);
  assign special    = ~special_mode_n_i;
  assign pgm        = ctrl_reg[`EEC_CTRL_PGM];
  assign lat        = ctrl_reg[`EEC_CTRL_LAT];
  assign erase      = ctrl_reg[`EEC_CTRL_ERASE];
  assign clock_divider_value = {clock_divider_high_reg, clock_divider_low_reg};
  assign div_zero   = (clock_divider_value == 10'h000);
  assign arr_hit    = (bus_addr_i[11:10] == `EEC_ARR_SEL);
  assign arr_ofs    = bus_addr_i[9:0];
  assign shadow_hit = arr_hit & ~module_config_register_reg[`EEC_MCR_SHADOW_DISABLE]
                    & ({arr_ofs[9:1], 1'b0} == `EEC_SHADOW_HI);
  assign wr_mcr     = bus_wr_i & ~load & (bus_addr_i == `EEC_OFS_MCR);
  assign wr_prot    = bus_wr_i & ~load & (bus_addr_i == `EEC_OFS_PROT);
  assign wr_ctrl    = bus_wr_i & ~load & (bus_addr_i == `EEC_OFS_CTRL);
  assign wr_divh    = bus_wr_i & ~load & (bus_addr_i == `EEC_OFS_DIVH);
  assign wr_divl    = bus_wr_i & ~load & (bus_addr_i == `EEC_OFS_DIVL);

  // array writes only land in the latches while latch is set and the program bit is clear
  assign latch_wr   = bus_wr_i & ~load & arr_hit & lat & ~pgm;

  // program bit needs latch already set and a usable divider
  assign pgm_set_ok = bus_wdata_i[`EEC_CTRL_PGM] & lat & ~div_zero;

  // row or bulk erase may sweep the shadow word with it
  assign multi_erase  = erase & ~ctrl_reg[`EEC_CTRL_BYTE];
  assign shadow_all   = multi_erase & ~module_config_register_reg[`EEC_MCR_SHADOW_DISABLE]
                      & (~ctrl_reg[`EEC_CTRL_ROW]
                         | ({op_reg.addr[9:5], 5'h00} == `EEC_SHADOW_HI));
  assign shadow_touch = op_reg.shadow | shadow_all;
  assign blocked = (shadow_touch & block_protect_register_reg[`EEC_PROT_SH])
                 | (~op_reg.shadow & blk_prot(op_reg.addr, block_protect_register_reg[4:0]))
                 | (multi_erase & ctrl_reg[`EEC_CTRL_BULKP]);
  // a protected target leaves the program bit set but never starts the pulse
  assign start = idle & wr_ctrl & ~pgm & pgm_set_ok & ~blocked;
  assign abort = wr_ctrl & pgm & ~bus_wdata_i[`EEC_CTRL_PGM];

  // control register: option and latch bits frozen while program is set
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
    begin
      if (pgm)
        ctrl_next[`EEC_CTRL_PGM] = bus_wdata_i[`EEC_CTRL_PGM];
      else
      begin
        if (!module_config_register_reg[`EEC_MCR_LCK])
          ctrl_next[`EEC_CTRL_BULKP] = bus_wdata_i[`EEC_CTRL_BULKP];
        ctrl_next[5:2] = bus_wdata_i[5:2];
        if (!div_zero)
          ctrl_next[`EEC_CTRL_LAT] = bus_wdata_i[`EEC_CTRL_LAT];
        ctrl_next[`EEC_CTRL_PGM] = pgm_set_ok;
      end
    end
    if (done && ctrl_reg[`EEC_CTRL_AUTO])
      ctrl_next[`EEC_CTRL_PGM] = 1'b0;
  end

  // config register: top nibble only writable in special mode
  always_comb
  begin
    mcr_next = module_config_register_reg;
    if (load)
      mcr_next[7:4] = shadow_reg[15:12];
    else if (wr_mcr)
    begin
      if (special)
        mcr_next[7:4] = bus_wdata_i[7:4];
      if (special || !lck_once_reg)
        mcr_next[`EEC_MCR_LCK] = bus_wdata_i[`EEC_MCR_LCK];
      mcr_next[`EEC_MCR_SWAI] = bus_wdata_i[`EEC_MCR_SWAI];
      mcr_next[`EEC_MCR_DMY]  = bus_wdata_i[`EEC_MCR_DMY];
    end
    mcr_next[`EEC_MCR_ONE] = 1'b1;
  end

  // sequencer: one load cycle after reset, then idle and busy
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      eec_pkg::EEC_ST_LOAD: state_next = eec_pkg::EEC_ST_IDLE;
      eec_pkg::EEC_ST_IDLE: if (start) state_next = eec_pkg::EEC_ST_BUSY;
      eec_pkg::EEC_ST_BUSY: if (done || abort) state_next = eec_pkg::EEC_ST_IDLE;
      default:              state_next = eec_pkg::EEC_ST_IDLE;
    endcase
  end

  eec_pulse_timer #(
    .DIV_W  (10),
    .TICK_W (9),
    .TICKS  (TICKS)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (state_reg == eec_pkg::EEC_ST_BUSY && !abort),
    .div_i     (clock_divider_value),
    .done_o    (done)
  );

  // read data: one cycle after the strobe, zero otherwise
  assign rd_mux = (bus_addr_i == `EEC_OFS_MCR)  ? module_config_register_reg :
                  (bus_addr_i == `EEC_OFS_PROT) ? block_protect_register_reg :
                  (bus_addr_i == `EEC_OFS_CTRL) ? ctrl_reg :
                  (bus_addr_i == `EEC_OFS_DIVH) ? {6'h00, clock_divider_high_reg} :
                  (bus_addr_i == `EEC_OFS_DIVL) ? clock_divider_low_reg :
                  shadow_hit ? (arr_ofs[0] ? shadow_reg[7:0] : shadow_reg[15:8]) :
                  arr_hit ? arr_rdata_i : 8'h00;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg                  <= eec_pkg::EEC_ST_LOAD;
      module_config_register_reg <= `EEC_MCR_RST;
      block_protect_register_reg <= `EEC_PROT_RST;
      ctrl_reg                   <= `EEC_CTRL_RST;
      rdata_reg                  <= 8'h00;
      lck_once_reg               <= 1'b0;
    end
    else
    begin
      state_reg                  <= state_next;
      module_config_register_reg <= mcr_next;
      ctrl_reg                   <= ctrl_next;
      rdata_reg                  <= bus_rd_i ? rd_mux : 8'h00;
      if (wr_mcr)
        lck_once_reg <= 1'b1;
      if (wr_prot && !pgm && !module_config_register_reg[`EEC_MCR_LCK])
        block_protect_register_reg <= {bus_wdata_i[7], 2'h0, bus_wdata_i[4:0]};
    end
  end

  // dividers: loaded from shadow, then write once in normal mode
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      clock_divider_high_reg <= 2'h0;
      clock_divider_low_reg  <= 8'h00;
      div_lock_hi_reg        <= 1'b0;
      div_lock_lo_reg        <= 1'b0;
    end
    else if (load)
    begin
      clock_divider_high_reg <= shadow_reg[9:8];
      clock_divider_low_reg  <= shadow_reg[7:0];
    end
    else
    begin
      if (wr_divh && (special || !div_lock_hi_reg))
      begin
        clock_divider_high_reg <= bus_wdata_i[1:0];
        div_lock_hi_reg        <= 1'b1;
      end
      if (wr_divl && (special || !div_lock_lo_reg))
      begin
        clock_divider_low_reg <= bus_wdata_i;
        div_lock_lo_reg       <= 1'b1;
      end
    end
  end

  // address and data latches, high voltage to the array
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      op_reg <= '0;
      hv_reg <= 1'b0;
    end
    else
    begin
      if (latch_wr)
        op_reg <= '{addr: arr_ofs, data: bus_wdata_i, shadow: shadow_hit};
      if (start)
        hv_reg <= ~op_reg.shadow | multi_erase;
      else if (done || abort)
        hv_reg <= 1'b0;
    end
  end

  // shadow word update at the end of a completed pulse; programming only clears bits
  always_ff @(posedge ref_clk_i)
  begin
    if (done && shadow_all)
      shadow_reg <= 16'hFFFF;
    else if (done && op_reg.shadow)
    begin
      if (op_reg.addr[0])
        shadow_reg[7:0] <= erase ? 8'hFF : shadow_reg[7:0] & op_reg.data;
      else
        shadow_reg[15:8] <= erase ? 8'hFF : shadow_reg[15:8] & op_reg.data;
    end
  end

  assign bus_rdata_o             = rdata_reg;
  assign arr_addr_o              = op_reg.addr;
  assign arr_wdata_o             = op_reg.data;
  assign arr_erase_o             = ctrl_reg[`EEC_CTRL_ERASE];
  assign arr_erase_mode_o        = ctrl_reg[`EEC_CTRL_BYTE:`EEC_CTRL_ROW];
  assign arr_hv_o                = hv_reg;
  assign arr_latch_o             = lat;
  assign debug_lockout_disable_o = module_config_register_reg[`EEC_MCR_DBG];
  assign flash_program_open_o    = module_config_register_reg[`EEC_MCR_FPO];

endmodule : eec_ctrl

// *** rtl/eec_pkg.sv ***
package eec_pkg;

  typedef enum logic [1:0]
  {
    EEC_ST_LOAD = 2'b00,
    EEC_ST_IDLE = 2'b01,
    EEC_ST_BUSY = 2'b10
  } eec_state_e;

  // latched target of one program or erase cycle
  typedef struct packed
  {
    logic [9:0] addr;
    logic [7:0] data;
    logic       shadow;
  } eec_op_s;

endpackage : eec_pkg

// *** rtl/eec_pulse_timer.sv ***
`timescale 1ns/1ns
`include "eec_cfg.svh"

module eec_pulse_timer #(
  parameter int DIV_W  = 10,
  parameter int TICK_W = 9,
  parameter int TICKS  = `EEC_PROG_TICKS
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  done_o
);

  logic [DIV_W-1:0]  pre_reg;
  logic [TICK_W-1:0] tick_reg;
  logic              pre_wrap;
  logic              tick_end;

  // prescaler gives one tick per divider count of oscillator cycles
  assign pre_wrap = (pre_reg == div_i - DIV_W'(1));
  assign tick_end = (tick_reg == TICK_W'(TICKS - 1));

  // stopping run restarts the count, so an aborted pulse never resumes
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !run_i)
    begin
      pre_reg  <= '0;
      tick_reg <= '0;
      done_o   <= 1'b0;
    end
    else
    begin
      done_o  <= pre_wrap & tick_end;
      pre_reg <= pre_wrap ? '0 : pre_reg + DIV_W'(1);
      if (pre_wrap)
        tick_reg <= tick_end ? '0 : tick_reg + TICK_W'(1);
    end
  end

endmodule : eec_pulse_timer

// *** test/eec_array_model.sv ***
`timescale 1ns/1ns
module eec_array_model (
  input  wire logic        ref_clk_i,
  input  wire logic [11:0] bus_addr_i,
  input  wire logic [9:0]  arr_addr_i,
  input  wire logic [7:0]  arr_wdata_i,
  input  wire logic        arr_erase_i,
  input  wire logic        arr_hv_i,
  output logic      [7:0]  arr_rdata_o
);
  // blank part: every cell starts erased; one driver per variable
  logic [7:0] mem [1024] = '{default: 8'hFF};
  logic       hv_q       = 1'b0;

  assign arr_rdata_o = mem[bus_addr_i[9:0]];

  // cell changes only at pulse end, programming only clears bits
  always @(posedge ref_clk_i)
  begin
    hv_q <= arr_hv_i;
    if (hv_q && !arr_hv_i)
      mem[arr_addr_i] <= arr_erase_i ? 8'hFF : (mem[arr_addr_i] & arr_wdata_i);
  end
endmodule : eec_array_model

// *** test/eec_ctrl_props.sv ***
`timescale 1ns/1ns
module eec_ctrl_props #(
  parameter int TICKS = 2
) (
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        special_mode_n_i,
  input wire logic [11:0] bus_addr_i,
  input wire logic [7:0]  bus_wdata_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_rd_i,
  input wire logic [7:0]  bus_rdata_o,
  input wire logic [9:0]  arr_addr_o,
  input wire logic [7:0]  arr_wdata_o,
  input wire logic        arr_erase_o,
  input wire logic [1:0]  arr_erase_mode_o,
  input wire logic        arr_hv_o,
  input wire logic        arr_latch_o,
  input wire logic        debug_lockout_disable_o,
  input wire logic        flash_program_open_o
);
  int hv_len;

  // pulse length counter, too long for a repetition operator
  always_ff @(posedge ref_clk_i)
  begin
    hv_len <= (sys_rst_i || !arr_hv_o) ? 0 : hv_len + 1;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_hv_rise;
    !arr_hv_o ##1 arr_hv_o;
  endsequence
  sequence s_hv_end;
    arr_hv_o ##1 !arr_hv_o;
  endsequence

  a_hv_cause: assert property (s_hv_rise |-> $past(bus_wr_i) && arr_latch_o
    && $past(bus_addr_i) == 12'h0F3 && $past(bus_wdata_i[0]))
    else $error("pulse started without program request");
  a_hv_latch: assert property (arr_hv_o |-> arr_latch_o)
    else $error("pulse without latch");
  a_target_hold: assert property (arr_hv_o && $past(arr_hv_o) |->
    $stable(arr_addr_o) && $stable(arr_wdata_o))
    else $error("target moved in pulse");
  a_opts_hold: assert property (arr_hv_o && $past(arr_hv_o) |->
    $stable(arr_erase_o) && $stable(arr_erase_mode_o))
    else $error("options moved in pulse");
  a_latch_hold: assert property ($fell(arr_latch_o) |-> !$past(arr_hv_o))
    else $error("latch dropped in pulse");
  a_pulse_min: assert property (s_hv_end ##0 !$past(bus_wr_i) |-> hv_len >= TICKS)
    else $error("pulse too short");
  a_pulse_max: assert property (hv_len <= TICKS * 1024 + 2)
    else $error("pulse never ends");
  a_rdata_idle: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  a_cfg_lock: assert property (special_mode_n_i && $past(special_mode_n_i)
    && !$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
    $stable(debug_lockout_disable_o) && $stable(flash_program_open_o))
    else $error("config bits moved in normal mode");
endmodule : eec_ctrl_props

bind eec_ctrl eec_ctrl_props #(.TICKS(TICKS)) i_props (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .special_mode_n_i(special_mode_n_i),
  .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
  .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .arr_addr_o(arr_addr_o),
  .arr_wdata_o(arr_wdata_o), .arr_erase_o(arr_erase_o),
  .arr_erase_mode_o(arr_erase_mode_o), .arr_hv_o(arr_hv_o), .arr_latch_o(arr_latch_o),
  .debug_lockout_disable_o(debug_lockout_disable_o),
  .flash_program_open_o(flash_program_open_o));

// *** test/eec_ctrl_tb.sv ***
`timescale 1ns/1ns
module eec_ctrl_tb;
  localparam int T = 2;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        mode_n    = 1'b1;
  logic [11:0] addr      = 12'h000;
  logic [7:0]  wd        = 8'h00;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        rd_d      = 1'b0;
  logic [7:0]  d1;
  logic [7:0]  d2;
  logic [7:0]  expq [$];
  wire  [7:0]  rdata;
  wire  [7:0]  ardata;
  wire  [7:0]  awd;
  wire  [9:0]  aaddr;
  wire         aer;
  wire         ahv;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cyc  = 0;
  int          dv   = 2;
  int          seed = 80646;

  initial
  begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  eec_ctrl #(.TICKS(T)) i_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .special_mode_n_i(mode_n),
    .bus_addr_i(addr), .bus_wdata_i(wd), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_rdata_o(rdata), .arr_rdata_i(ardata), .arr_addr_o(aaddr), .arr_wdata_o(awd),
    .arr_erase_o(aer), .arr_erase_mode_o(), .arr_hv_o(ahv), .arr_latch_o(),
    .debug_lockout_disable_o(), .flash_program_open_o());

  eec_array_model i_arr (
    .ref_clk_i(ref_clk_i), .bus_addr_i(addr), .arr_addr_i(aaddr),
    .arr_wdata_i(awd), .arr_erase_i(aer), .arr_hv_i(ahv), .arr_rdata_o(ardata));

  task end_sim;
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: read %h, wanted %h", $time, seen, exp);
      miscompares++;
    end
  endtask : chk

  task wr_t(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wr_t

  task rd_t(input logic [11:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
  endtask : rd_t

  // options with latch, one byte, program; waits out the pulse
  task prog(input logic [11:0] a, input logic [7:0] d, input logic [7:0] opt);
    wr_t(12'h0F3, opt);
    wr_t(a, d);
    wr_t(12'h0F3, opt | 8'h01);
    repeat (dv * T + 4) @(posedge ref_clk_i);
  endtask : prog

  // the edge after release is the shadow load cycle
  task reset(input logic m);
    sys_rst_i <= 1'b1;
    mode_n <= m;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : reset

  // read answers come one cycle after the strobe, oldest note first
  always @(posedge ref_clk_i)
  begin
    rd_d <= rd;
    if (rd_d)
      chk(rdata, expq.pop_front());
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    reset(1'b1);
    rd_t(12'h0F0, 8'hFC);
    rd_t(12'h0EE, 8'h03);
    rd_t(12'h0EF, 8'hFF);
    wr_t(12'h0EE, 8'h00);
    wr_t(12'h0EF, 8'h00);
    wr_t(12'h0EF, 8'h05);
    rd_t(12'h0EF, 8'h00);
    // unlocked control write also clears bulk protect; latch refused at zero divider
    wr_t(12'h0F3, 8'h02);
    rd_t(12'h0F3, 8'h00);
    reset(1'b0);
    wr_t(12'h0EE, 8'h00);
    wr_t(12'h0EF, 8'h02);
    wr_t(12'h0F1, 8'h00);
    wr_t(12'h0F3, 8'h03);
    rd_t(12'h0F3, 8'h02);
    prog(12'hC10, d1, 8'h02);
    rd_t(12'h0F3, 8'h03);
    wr_t(12'h0F3, 8'h02);
    prog(12'hC11, d2, 8'h22);
    rd_t(12'h0F3, 8'h22);
    prog(12'hC10, 8'h00, 8'h36);
    rd_t(12'h0F3, 8'h36);
    wr_t(12'h0F3, 8'h00);
    rd_t(12'hC10, 8'hFF);
    rd_t(12'hC11, d2);
    // shadow store: unprotected, enabled, only divider bits cleared
    wr_t(12'h0F0, 8'hBC);
    prog(12'hFC0, 8'hFD, 8'h22);
    prog(12'hFC1, 8'h03, 8'h22);
    wr_t(12'h0F3, 8'h00);
    wr_t(12'h0F1, 8'h80);
    rd_t(12'hFC0, 8'hFD);
    rd_t(12'hFC1, 8'h03);
    wr_t(12'h0F0, 8'hFC);
    rd_t(12'hFC0, 8'hFF);
    reset(1'b1);
    rd_t(12'h0F0, 8'hFC);
    rd_t(12'h0EE, 8'h01);
    rd_t(12'h0EF, 8'h03);
    wr_t(12'h0EE, 8'h00);
    wr_t(12'h0EF, 8'h02);
    wr_t(12'h0EF, 8'h09);
    rd_t(12'h0EF, 8'h02);
    wr_t(12'h0F1, 8'h80);
    prog(12'hC20, d1, 8'h22);
    wr_t(12'h0F3, 8'h00);
    rd_t(12'hC20, d1);
    repeat (3) @(posedge ref_clk_i);
    end_sim();
  end
endmodule : eec_ctrl_tb
